// ==== logic/atpg_consts.svh ====
// Constants for the test pattern generator
// How it works
// R1: Low nibble of control selects normal, midscale, full scales, checkerboard, toggle.
// R2: Mode 0101 outputs the long pseudorandom sequence instead of samples.
// R3: Control bit 5 high holds the long generator in reset.
// R4: Mode 0110 outputs the short pseudorandom sequence instead of samples.
// R5: Control bit 4 high holds the short generator in reset.
// R6: Mode 1000 outputs the four user patterns per the sequencing bit.
// R7: Sequencing bit 7 matters only in user pattern mode.
// R8: Bit 7 low repeats patterns one to four, one cycle each.
// R9: Bit 7 high plays patterns one to four once, then zeros.
// R10: Each pattern comes from a low and high byte register pair.
// R11: Low register gives bits 7:0, high register bits 15:8.
// R12: Reserved control bit 6 reads zero and is not stored.
// R13: Mode change acts next cycle; re-entering user mode restarts at pattern one.
`ifndef ATPG_CONSTS_SVH
`define ATPG_CONSTS_SVH
`define ATPG_IDX_CTRL 12'h550
`define ATPG_IDX_USER_FIRST 12'h551
`define ATPG_IDX_USER_LAST 12'h558
`define ATPG_IDX_SAMPLE_IN 12'h5F0
`define ATPG_IDX_STATUS 12'h5F1
`define ATPG_CTRL_RESET 8'h00
`define ATPG_CTRL_MASK 8'hBF
`define ATPG_BIT_SEQ_ONCE 7
`define ATPG_BIT_LONG_HOLD 5
`define ATPG_BIT_SHORT_HOLD 4
`define ATPG_MODE_NORMAL 4'h0
`define ATPG_MODE_MID 4'h1
`define ATPG_MODE_POS 4'h2
`define ATPG_MODE_NEG 4'h3
`define ATPG_MODE_CHECK 4'h4
`define ATPG_MODE_LONG 4'h5
`define ATPG_MODE_SHORT 4'h6
`define ATPG_MODE_TOGGLE 4'h7
`define ATPG_MODE_USER 4'h8
`define ATPG_WORD_MID 16'h8000
`define ATPG_WORD_POS 16'hFFFF
`define ATPG_WORD_NEG 16'h0000
`define ATPG_WORD_CHECK 16'hAAAA
`define ATPG_WORD_ONES 16'hFFFF
`define ATPG_LONG_SEED 23'h7FFFFF
`define ATPG_SHORT_SEED 9'h1FF
`define ATPG_SLV_OKAY 2'h0
`define ATPG_SLV_ERR 2'h2
`endif

// ==== logic/atpg_pkg.sv ====
// Types for the test pattern generator
package atpg_pkg;
    typedef struct packed {
        logic seq_once;
        logic long_hold;
        logic short_hold;
        logic [3:0] mode;
    } atpg_ctrl_t;
    typedef enum logic [2:0] {
        ATPG_SEQ_IDLE,
        ATPG_SEQ_W1,
        ATPG_SEQ_W2,
        ATPG_SEQ_W3,
        ATPG_SEQ_W4,
        ATPG_SEQ_ZERO
    } atpg_seq_t;
endpackage

// ==== logic/atpg_prbs.sv ====
// Pseudorandom word generator with hold-in-reset
module atpg_prbs #(
    parameter int LEN = 23,
    parameter int TAP = 18,
    parameter logic [LEN-1:0] SEED = '1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic hold,
    // Word out
    output logic [15:0] word
);
    logic [LEN-1:0] state;
    logic [LEN-1:0] next_state;
    logic [15:0] next_word;

    // Advance sixteen bits per cycle, word keeps the newest sixteen
    always_comb begin
        next_state = state;
        next_word = word;
        for (int i = 0; i < 16; i++) begin
            next_word = {next_word[14:0], next_state[LEN-1] ^ next_state[TAP-1]};
            next_state = {next_state[LEN-2:0], next_state[LEN-1] ^ next_state[TAP-1]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || hold) begin
            state <= SEED;
            word <= '1;
        end else begin
            state <= next_state;
            word <= next_word;
        end
    end
endmodule

// ==== logic/atpg_top.sv ====
// Test pattern generator with AXI4-Lite control registers
`include "atpg_consts.svh"
module atpg_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Converter samples
    input wire logic [15:0] sample_in,
    input wire logic sample_valid,
    // Output path
    output logic [15:0] data_out,
    output logic data_valid,
    // AXI4-Lite write address
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ========================================
    // Registers
    atpg_pkg::atpg_ctrl_t ctrl;
    logic [7:0] user_byte [0:7];
    atpg_pkg::atpg_seq_t seq;
    atpg_pkg::atpg_seq_t next_seq;
    logic [3:0] prev_mode;
    logic toggle;
    logic [15:0] long_word;
    logic [15:0] short_word;
    logic [15:0] next_data;
    logic [15:0] user_word [0:3];

    // ========================================
    // Write channel
    logic aw_held;
    logic w_held;
    logic [15:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic do_write;
    logic [11:0] w_idx;
    logic w_hit;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign w_idx = aw_addr[13:2];
    assign w_hit = (w_idx == `ATPG_IDX_CTRL)
        || (w_idx >= `ATPG_IDX_USER_FIRST && w_idx <= `ATPG_IDX_USER_LAST);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 16'h0000;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_wready;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ATPG_SLV_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? `ATPG_SLV_OKAY : `ATPG_SLV_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register, reserved bit not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= atpg_pkg::atpg_ctrl_t'(7'h00);
        end else if (do_write && w_lane && w_idx == `ATPG_IDX_CTRL) begin
            ctrl.seq_once <= w_byte[`ATPG_BIT_SEQ_ONCE];
            ctrl.long_hold <= w_byte[`ATPG_BIT_LONG_HOLD]; // [R3]
            ctrl.short_hold <= w_byte[`ATPG_BIT_SHORT_HOLD]; // [R5] [R12]
            ctrl.mode <= w_byte[3:0]; // [R1]
        end
    end

    // User pattern byte registers
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gen_user
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    user_byte[g] <= 8'h00;
                end else if (do_write && w_lane
                    && w_idx == `ATPG_IDX_USER_FIRST + 12'(g)) begin
                    user_byte[g] <= w_byte; // [R10]
                end
            end
        end
        for (g = 0; g < 4; g++) begin : gen_word
            assign user_word[g] = {user_byte[2*g+1], user_byte[2*g]}; // [R11]
        end
    endgenerate

    // ========================================
    // Read channel
    logic [11:0] r_idx;
    logic [7:0] ctrl_byte;

    assign r_idx = s_axi_araddr[13:2];
    assign ctrl_byte = {ctrl.seq_once, 1'b0, ctrl.long_hold, ctrl.short_hold,
        ctrl.mode}; // [R12]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ATPG_SLV_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ATPG_SLV_OKAY;
            if (r_idx == `ATPG_IDX_CTRL) begin
                s_axi_rdata <= {24'h000000, ctrl_byte};
            end else if (r_idx >= `ATPG_IDX_USER_FIRST && r_idx <= `ATPG_IDX_USER_LAST) begin
                s_axi_rdata <= {24'h000000, user_byte[3'(r_idx - `ATPG_IDX_USER_FIRST)]};
            end else if (r_idx == `ATPG_IDX_SAMPLE_IN) begin
                s_axi_rdata <= {16'h0000, data_out};
            end else if (r_idx == `ATPG_IDX_STATUS) begin
                s_axi_rdata <= {29'h00000000, seq};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `ATPG_SLV_ERR;
            end
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= !s_axi_arready;
        end
    end

    // ========================================
    // Pseudorandom generators
    atpg_prbs #(.LEN(23), .TAP(18), .SEED(`ATPG_LONG_SEED)) u_long (
        .aclk(aclk),
        .aresetn(aresetn),
        .hold(ctrl.long_hold), // [R3]
        .word(long_word)
    );

    atpg_prbs #(.LEN(9), .TAP(5), .SEED(`ATPG_SHORT_SEED)) u_short (
        .aclk(aclk),
        .aresetn(aresetn),
        .hold(ctrl.short_hold), // [R5]
        .word(short_word)
    );

    // ========================================
    // User sequence
    always_comb begin
        next_seq = seq;
        if (ctrl.mode != `ATPG_MODE_USER || prev_mode != `ATPG_MODE_USER) begin
            next_seq = atpg_pkg::ATPG_SEQ_W1; // [R13]
        end else begin
            unique case (seq)
                atpg_pkg::ATPG_SEQ_IDLE: next_seq = atpg_pkg::ATPG_SEQ_W1;
                atpg_pkg::ATPG_SEQ_W1: next_seq = atpg_pkg::ATPG_SEQ_W2;
                atpg_pkg::ATPG_SEQ_W2: next_seq = atpg_pkg::ATPG_SEQ_W3;
                atpg_pkg::ATPG_SEQ_W3: next_seq = atpg_pkg::ATPG_SEQ_W4;
                atpg_pkg::ATPG_SEQ_W4: begin
                    next_seq = ctrl.seq_once ? atpg_pkg::ATPG_SEQ_ZERO // [R9]
                        : atpg_pkg::ATPG_SEQ_W1; // [R8]
                end
                atpg_pkg::ATPG_SEQ_ZERO: next_seq = atpg_pkg::ATPG_SEQ_ZERO; // [R9]
                default: next_seq = atpg_pkg::ATPG_SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq <= atpg_pkg::ATPG_SEQ_IDLE;
            prev_mode <= `ATPG_MODE_NORMAL;
        end else begin
            seq <= (ctrl.mode == `ATPG_MODE_USER) ? next_seq : atpg_pkg::ATPG_SEQ_IDLE;
            prev_mode <= ctrl.mode;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            toggle <= 1'b0;
        end else begin
            toggle <= !toggle;
        end
    end

    // ========================================
    // Output word select
    always_comb begin
        next_data = sample_in;
        unique case (ctrl.mode)
            `ATPG_MODE_NORMAL: next_data = sample_in;
            `ATPG_MODE_MID: next_data = `ATPG_WORD_MID; // [R1]
            `ATPG_MODE_POS: next_data = `ATPG_WORD_POS; // [R1]
            `ATPG_MODE_NEG: next_data = `ATPG_WORD_NEG; // [R1]
            `ATPG_MODE_CHECK: next_data = toggle ? ~`ATPG_WORD_CHECK : `ATPG_WORD_CHECK; // [R1]
            `ATPG_MODE_LONG: next_data = long_word; // [R2]
            `ATPG_MODE_SHORT: next_data = short_word; // [R4]
            `ATPG_MODE_TOGGLE: next_data = toggle ? ~`ATPG_WORD_ONES : `ATPG_WORD_ONES; // [R1]
            `ATPG_MODE_USER: begin
                unique case (next_seq) // [R6] [R7]
                    atpg_pkg::ATPG_SEQ_W1: next_data = user_word[0];
                    atpg_pkg::ATPG_SEQ_W2: next_data = user_word[1];
                    atpg_pkg::ATPG_SEQ_W3: next_data = user_word[2];
                    atpg_pkg::ATPG_SEQ_W4: next_data = user_word[3];
                    default: next_data = 16'h0000;
                endcase
            end
            default: next_data = sample_in;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_out <= 16'h0000;
            data_valid <= 1'b0;
        end else begin
            data_out <= next_data; // [R13]
            data_valid <= (ctrl.mode == `ATPG_MODE_NORMAL) ? sample_valid : 1'b1;
        end
    end
endmodule

// ==== tb/atpg_sample_source.sv ====
// Converter sample source feeding the generator
module atpg_sample_source (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Samples
    output logic [15:0] sample_in,
    output logic sample_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Ramp with gaps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_in <= 16'h0000;
            sample_valid <= 1'b0;
        end else begin
            sample_in <= sample_in + 16'h0101;
            sample_valid <= ~sample_valid;
        end
    end
endmodule

// ==== tb/atpg_top_sva.sv ====
// Concurrent checks for the test pattern generator
module atpg_top_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Stream
    input wire logic [15:0] sample_in,
    input wire logic [15:0] data_out,
    // Register bus
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ctl;
    logic [3:0] age;
    logic hit;
    // ==========
    // Shadow of the control register
    assign hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 16'h1540;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl <= 8'h00;
        end else if (hit) begin
            ctl <= s_axi_wdata[7:0];
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || hit) begin
            age <= 4'h0;
        end else if (age != 4'hF) begin
            age <= age + 4'h1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence settled(logic [3:0] m, logic b);
        age == 4'hF && ctl[3:0] == m && b;
    endsequence
    AST_NORMAL: assert property (settled(4'h0, 1'b1) |-> data_out == $past(sample_in))
        else $error("normal path word wrong");
    AST_MIDSCALE: assert property (settled(4'h1, 1'b1) |-> data_out == 16'h8000)
        else $error("midscale word wrong");
    AST_TOGGLE: assert property (settled(4'h7, 1'b1) |=> data_out == ~$past(data_out))
        else $error("word toggle stalled");
    AST_LONG_RUNS: assert property (settled(4'h5, !ctl[5]) |-> !$stable(data_out))
        else $error("long sequence stalled");
    AST_LONG_HOLD: assert property (settled(4'h5, ctl[5]) |-> $stable(data_out))
        else $error("long sequence not held");
    AST_SHORT_HOLD: assert property (settled(4'h6, ctl[4]) |-> $stable(data_out))
        else $error("short sequence not held");
    AST_USER_REPEAT: assert property (settled(4'h8, !ctl[7]) |-> data_out == $past(data_out, 4))
        else $error("user cycle not four words");
    AST_USER_ONCE: assert property (settled(4'h8, ctl[7]) |-> data_out == 16'h0000)
        else $error("zeros missing after user words");
    AST_WR_ANSWER: assert property (hit |-> ##[1:4] s_axi_bvalid)
        else $error("write response missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule
bind atpg_top atpg_top_sva atpg_top_sva_i (.aclk(aclk), .aresetn(aresetn),
    .sample_in(sample_in), .data_out(data_out), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready));

// ==== tb/atpg_top_test.sv ====
// Self-checking bench for the test pattern generator
module atpg_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] sample_in, data_out, awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic sample_valid, awready, wready, bvalid, arready, rvalid, dv, v;
    logic [1:0] bresp, rresp, r;
    logic [15:0] w;
    logic [15:0] pat [4] = '{16'hA1B2, 16'hC3D4, 16'hE5F6, 16'h0718};
    logic [15:0] lvl [8] = '{16'h0, 16'h8000, 16'hFFFF, 16'h0000, 16'hAAAA, 16'h0, 16'h0, 16'hFFFF};
    int ml [5] = '{1, 2, 3, 4, 7};
    int fails = 0;
    int samples_checked = 0;
    atpg_sample_source atpg_sample_source_i (.aclk(aclk), .aresetn(aresetn),
        .sample_in(sample_in), .sample_valid(sample_valid));
    atpg_top atpg_top_i (.aclk(aclk), .aresetn(aresetn), .sample_in(sample_in),
        .sample_valid(sample_valid), .data_out(data_out), .data_valid(dv),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ==========
    // Bus and compare tasks
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    task automatic print_verdict();
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic set_mode(input logic [7:0] v);
        repeat (16) @(posedge aclk);
        wr(16'h1540, v);
    endtask
    task automatic wait_word(input logic [15:0] x);
        int n = 0;
        @(negedge aclk);
        while (data_out !== x && n < 20) begin
            @(negedge aclk);
            n++;
        end
        check(32'(data_out), 32'(x), "first user word");
    endtask
    // ==========
    // Tests
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(16'h1540);
        check(d, 32'h0, "control reset value");
        wr(16'h1540, 8'hFF);
        rd(16'h1540);
        check(d, 32'hBF, "control readback");
        rd(16'h1600);
        check(32'(r), 32'h2, "unmapped read");
        wr(16'h1600, 8'h01);
        check(32'(r), 32'h2, "unmapped write");
        for (int k = 0; k < 4; k++) begin
            wr(16'h1544 + 16'(8 * k), pat[k][7:0]);
            wr(16'h1548 + 16'(8 * k), pat[k][15:8]);
        end
        rd(16'h1548);
        check(d, 32'(pat[0][15:8]), "user high byte");
        foreach (ml[i]) begin
            set_mode(8'h80 | 8'(ml[i]));
            repeat (3) @(negedge aclk);
            w = data_out;
            @(negedge aclk);
            check(32'(data_out ^ w), (ml[i] < 4) ? 32'h0 : 32'hFFFF, "alternation");
            check(32'(w === lvl[ml[i]] || data_out === lvl[ml[i]]), 32'h1, "level");
            check(32'(dv), 32'h1, "pattern valid");
        end
        set_mode(8'h80);
        @(negedge aclk);
        w = sample_in;
        v = sample_valid;
        @(negedge aclk);
        check(32'(data_out), 32'(w), "normal sample");
        check(32'(dv), 32'(v), "normal valid");
        for (int p = 0; p < 2; p++) begin
            set_mode(p == 0 ? 8'h25 : 8'h16);
            repeat (2) @(negedge aclk);
            w = data_out;
            @(negedge aclk);
            check(32'(data_out), 32'(w), "held generator");
            set_mode(p == 0 ? 8'h05 : 8'h06);
            @(negedge aclk);
            w = data_out;
            @(negedge aclk);
            check(32'(data_out != w), 32'h1, "running generator");
        end
        set_mode(8'h08);
        wait_word(pat[0]);
        for (int i = 1; i < 8; i++) begin
            @(negedge aclk);
            check(32'(data_out), 32'(pat[i % 4]), "repeat user word");
        end
        set_mode(8'h00);
        set_mode(8'h88);
        wait_word(pat[0]);
        for (int i = 1; i < 8; i++) begin
            @(negedge aclk);
            check(32'(data_out), (i < 4) ? 32'(pat[i]) : 32'h0, "single user word");
        end
        rd(16'h17C4);
        check(d, 32'h5, "sequencer parked on zeros");
        rd(16'h17C0);
        check(d, 32'h0, "output word readback");
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        print_verdict();
    end
endmodule
